// ===== hdl/rwi_pkg.sv
/*
 * Constants, types and reset values shared by the wake and init block.
 * Assumes nothing of its surroundings; included through rwi_pkg:: names.
 */
package rwi_pkg;
    // ************************************************
    // Vectors and widths
    // ************************************************
    localparam int PC_W = 21;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam int STACK_DEPTH = 31;
    localparam int PTR_W = 5;
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [4:0] PTR_LAST = 5'h1F;
    // ************************************************
    // Port A layout and reset values
    // ************************************************
    localparam int PA_BIT6 = 6;
    localparam logic [7:0] PA_MASK_BASE = 8'h3F;
    localparam logic [7:0] PA_MASK_BIT6 = 8'h40;
    localparam logic [7:0] PA_DIR_RESET = 8'h7F;
    localparam logic [7:0] PA_LAT_POWER_RESET = 8'h00;
    // Oscillator mode codes, arbitrary encodings
    localparam logic [3:0] OSC_EXT_IO = 4'h5;
    localparam logic [3:0] OSC_RC_IO = 4'h7;
    // Data bus register select
    localparam logic [1:0] SEL_PIN = 2'h0;
    localparam logic [1:0] SEL_LATCH = 2'h1;
    localparam logic [1:0] SEL_DIR = 2'h2;
    localparam logic [1:0] SEL_FLAGS = 2'h3;
    // ************************************************
    // Wake cause flags
    // ************************************************
    localparam int FLAG_WATCHDOG = 0;
    localparam int FLAG_LOW = 1;
    localparam int FLAG_HIGH = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAGS_IMPL = 8'h07;

    typedef enum logic [2:0] {
        RWI_RUN = 3'h1,
        RWI_SLEEP = 3'h2,
        RWI_WAKE = 3'h4
    } rwi_state_t;
endpackage

// ===== hdl/rwi_stack.sv
/*
 * Hardware return stack: stores pushed program counters, shows top bytes.
 * Assumes push comes from the wake controller on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module rwi_stack (
    input wire logic core_clk,
    input wire logic rst_n,
    rwi_stack_if.stack sif
);
    // ************************************************
    // Storage and pointer
    // ************************************************
    logic [20:0] mem [1:31];
    logic [4:0] ptr;
    logic full;
    logic [20:0] top;
    wire logic canPush = sif.push && (ptr != rwi_pkg::PTR_LAST);
    wire logic [4:0] next_ptr = ptr + 5'h01;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ptr <= rwi_pkg::PTR_RESET;
            full <= 1'b0;
        end else if (canPush) begin
            ptr <= next_ptr;
            full <= (next_ptr == rwi_pkg::PTR_LAST);
        end
    end

    always_ff @(posedge core_clk) begin
        if (canPush) begin
            mem[next_ptr] <= sif.pushData;
            top <= sif.pushData;
        end
    end

    assign sif.ptr = ptr;
    assign sif.topUpper = {3'h0, top[20:16]};
    assign sif.topHigh = top[15:8];
    assign sif.topLow = top[7:0];
    assign sif.full = full;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_push_advances_ptr: assert property (canPush |=> ptr == $past(ptr) + 5'h01)
        else $error("stack pointer did not advance on push");
    a_push_loads_top: assert property (canPush |=> top == $past(sif.pushData))
        else $error("top of stack not loaded with pushed value");
    a_upper_byte_zero: assert property (sif.topUpper[7:5] == 3'h0)
        else $error("unimplemented upper stack bits not zero");
endmodule
`default_nettype wire

// ===== hdl/rwi_stack_if.sv
/*
 * Carrier between the wake controller and the hardware return stack.
 * Assumes one clock, driven by the instantiating module.
 */
`timescale 1ns/1ns
`default_nettype none
interface rwi_stack_if;
    logic push;
    logic [20:0] pushData;
    logic [7:0] topUpper;
    logic [7:0] topHigh;
    logic [7:0] topLow;
    logic [4:0] ptr;
    logic full;
    modport ctrl (output push, output pushData, input topUpper, input topHigh, input topLow,
                  input ptr, input full);
    modport stack (input push, input pushData, output topUpper, output topHigh,
                   output topLow, output ptr, output full);
endinterface
`default_nettype wire

// ===== hdl/rwi_top.sv
/*
 * Wake-up and register initialisation block of the core: sleep and wake
 * sequencing, interrupt vectoring with return push, port A bit 6 gating
 * and per-reset-class initial values, plus separate fetch and data ports.
 * Assumes the core drives sleepReq, currentPc and the data port on core_clk;
 * port A pins are asynchronous and pass a two-stage synchroniser.
 */
`timescale 1ns/1ns
`default_nettype none
module rwi_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic resetIsPower,
    input wire logic bit6Present,
    input wire logic [3:0] oscMode,
    input wire logic sleepReq,
    input wire logic watchdogWake,
    input wire logic lowIrq,
    input wire logic highIrq,
    input wire logic lowGlobalEnable,
    input wire logic highGlobalEnable,
    input wire logic [20:0] currentPc,
    input wire logic [7:0] flagClr,
    input wire logic [7:0] portAPin,
    input wire logic dataWe,
    input wire logic [1:0] dataSel,
    input wire logic [7:0] dataWrData,
    output logic [7:0] dataRdData,
    output logic [20:0] progAddr,
    output logic pcLoad,
    output logic [20:0] pcLoadValue,
    output logic asleep,
    output logic [7:0] wakeFlags,
    output logic [7:0] portALatch,
    output logic [7:0] portADir,
    output logic [7:0] portAPinRead,
    output logic [7:0] stackTopUpper,
    output logic [7:0] stackTopHigh,
    output logic [7:0] stackTopLow,
    output logic [4:0] stackPtr,
    output logic stackFull
);
    // ************************************************
    // Stack
    // ************************************************
    rwi_stack_if sif ();
    rwi_stack u_stack (.core_clk(core_clk), .rst_n(rst_n), .sif(sif));
    assign stackTopUpper = sif.topUpper;
    assign stackTopHigh = sif.topHigh;
    assign stackTopLow = sif.topLow;
    assign stackPtr = sif.ptr;
    assign stackFull = sif.full;

    // ************************************************
    // Pin synchroniser and bit 6 gating
    // ************************************************
    logic [7:0] pinMeta;
    logic [7:0] pinSync;
    logic bit6Strap;
    always_ff @(posedge core_clk) begin
        pinMeta <= portAPin;
        pinSync <= pinMeta;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bit6Strap <= bit6Present;
        end
    end
    wire logic ioOscMode = (oscMode == rwi_pkg::OSC_EXT_IO) || (oscMode == rwi_pkg::OSC_RC_IO);
    wire logic bit6Live = bit6Strap && ioOscMode;
    wire logic [7:0] bit6Mask = bit6Live ? rwi_pkg::PA_MASK_BIT6 : 8'h00;
    wire logic [7:0] paMask = rwi_pkg::PA_MASK_BASE | bit6Mask;

    // ************************************************
    // Sleep and wake sequencing
    // ************************************************
    rwi_pkg::rwi_state_t state;
    rwi_pkg::rwi_state_t next_state;
    wire logic anyIrq = lowIrq || highIrq;
    wire logic anyGie = lowGlobalEnable || highGlobalEnable;
    wire logic wakeNow = (state == rwi_pkg::RWI_SLEEP) && (watchdogWake || anyIrq);
    wire logic vectorNow = wakeNow && !watchdogWake && anyGie;
    wire logic takeHigh = highIrq && highGlobalEnable;
    wire logic [20:0] next_vector = takeHigh ? rwi_pkg::VEC_HIGH : rwi_pkg::VEC_LOW;
    wire logic [20:0] next_pcValue = vectorNow ? next_vector : currentPc;
    assign sif.push = vectorNow;
    assign sif.pushData = currentPc;

    always_comb begin
        next_state = state;
        case (state)
            rwi_pkg::RWI_RUN: begin
                if (sleepReq) begin
                    next_state = rwi_pkg::RWI_SLEEP;
                end
            end
            rwi_pkg::RWI_SLEEP: begin
                if (wakeNow) begin
                    next_state = rwi_pkg::RWI_WAKE;
                end
            end
            default: begin
                next_state = rwi_pkg::RWI_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= rwi_pkg::RWI_RUN;
            pcLoad <= 1'b0;
            pcLoadValue <= 21'h000000;
            asleep <= 1'b0;
        end else begin
            state <= next_state;
            pcLoad <= wakeNow;
            pcLoadValue <= wakeNow ? next_pcValue : pcLoadValue;
            asleep <= (next_state == rwi_pkg::RWI_SLEEP);
        end
    end

    // ************************************************
    // Wake cause flags, set wins over clear
    // ************************************************
    logic [7:0] flagSet;
    always_comb begin
        flagSet = 8'h00;
        flagSet[rwi_pkg::FLAG_WATCHDOG] = wakeNow && watchdogWake;
        flagSet[rwi_pkg::FLAG_LOW] = wakeNow && lowIrq;
        flagSet[rwi_pkg::FLAG_HIGH] = wakeNow && highIrq;
    end
    wire logic [7:0] next_flags = ((wakeFlags & ~flagClr) | flagSet) & rwi_pkg::FLAGS_IMPL;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wakeFlags <= rwi_pkg::FLAGS_RESET;
        end else begin
            wakeFlags <= next_flags;
        end
    end

    // ************************************************
    // Port A registers and data port
    // ************************************************
    logic [7:0] latRaw;
    logic [7:0] dirRaw;
    wire logic latWr = dataWe && (dataSel == rwi_pkg::SEL_LATCH);
    wire logic dirWr = dataWe && (dataSel == rwi_pkg::SEL_DIR);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dirRaw <= rwi_pkg::PA_DIR_RESET;
            latRaw <= resetIsPower ? rwi_pkg::PA_LAT_POWER_RESET : latRaw;
        end else begin
            dirRaw <= dirWr ? dataWrData : dirRaw;
            latRaw <= latWr ? dataWrData : latRaw;
        end
    end
    wire logic [7:0] latView = latRaw & paMask;
    wire logic [7:0] dirView = dirRaw & paMask;
    wire logic [7:0] pinView = pinSync & paMask;
    wire logic [7:0] next_rd = (dataSel == rwi_pkg::SEL_PIN) ? pinView :
                               (dataSel == rwi_pkg::SEL_LATCH) ? latView :
                               (dataSel == rwi_pkg::SEL_DIR) ? dirView : wakeFlags;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            portALatch <= 8'h00;
            portADir <= 8'h00;
            portAPinRead <= 8'h00;
            dataRdData <= 8'h00;
            progAddr <= 21'h000000;
        end else begin
            portALatch <= latView;
            portADir <= dirView;
            portAPinRead <= pinView;
            dataRdData <= next_rd;
            progAddr <= wakeNow ? next_pcValue : currentPc;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_vector_high_load: assert property (
        wakeNow && !watchdogWake && takeHigh |=> pcLoad && pcLoadValue == rwi_pkg::VEC_HIGH)
        else $error("high vector not loaded on enabled wake");
    a_vector_low_load: assert property (
        wakeNow && !watchdogWake && !takeHigh && lowIrq && lowGlobalEnable
        |=> pcLoad && pcLoadValue == rwi_pkg::VEC_LOW)
        else $error("low vector not loaded on enabled wake");
    a_push_with_vector: assert property (
        vectorNow && !sif.full |=> sif.ptr == $past(sif.ptr) + 5'h01
        && {sif.topUpper[4:0], sif.topHigh, sif.topLow} == $past(currentPc))
        else $error("return address not pushed on vector wake");
    a_wake_cause_flag: assert property (
        wakeNow |=> (wakeFlags & rwi_pkg::FLAGS_IMPL) != 8'h00)
        else $error("wake left no cause flag");
    a_bit6_gated: assert property (
        !bit6Live |=> !portALatch[rwi_pkg::PA_BIT6] && !portADir[rwi_pkg::PA_BIT6]
        && !portAPinRead[rwi_pkg::PA_BIT6])
        else $error("port A bit 6 visible while disabled");
    a_unimpl_zero: assert property (
        !portALatch[7] && !portADir[7] && !portAPinRead[7] && wakeFlags[7:3] == 5'h00)
        else $error("unimplemented bit reads nonzero");
    a_dir_after_reset: assert property (
        $rose(rst_n) |=> portADir == (rwi_pkg::PA_DIR_RESET & paMask))
        else $error("direction register not at reset value");
    a_fetch_data_same: assert property (
        state == rwi_pkg::RWI_RUN ##0 !wakeNow
        |=> progAddr == $past(currentPc) && dataRdData == $past(next_rd))
        else $error("fetch and data access not concurrent");
    a_resume_no_stack: assert property (
        wakeNow && (watchdogWake || !anyGie)
        |=> pcLoad && pcLoadValue == $past(currentPc) && sif.ptr == $past(sif.ptr))
        else $error("plain wake vectored or stacked");

    c_high_vector: cover property (vectorNow && takeHigh);
    c_low_vector: cover property (vectorNow && !takeHigh);
    c_watchdog_wake: cover property (wakeNow && watchdogWake);
    c_plain_irq_wake: cover property (wakeNow && !watchdogWake && !anyGie);
endmodule
`default_nettype wire

// ===== testbench/rwi_top_tb.sv
/*
 * Self-checking bench for rwi_top: reset classes, data port, bit 6 gating, wakes.
 * Assumes the rwi_top ports and rwi_pkg constants as delivered.
 */
`timescale 1ns/1ns
`default_nettype none
module rwi_top_tb;
    logic core_clk, rst_n, resetIsPower, bit6Present, sleepReq, watchdogWake, lowIrq, highIrq;
    logic lowGlobalEnable, highGlobalEnable, dataWe, pcLoad, asleep, stackFull;
    logic [3:0] oscMode;
    logic [20:0] currentPc, progAddr, pcLoadValue;
    logic [7:0] flagClr, portAPin, dataWrData, dataRdData, wakeFlags, portALatch, portADir;
    logic [7:0] portAPinRead, stackTopUpper, stackTopHigh, stackTopLow, bit6Exp;
    logic [1:0] dataSel;
    logic [4:0] stackPtr, expPtr;
    logic [3:0] modes [4] = '{4'h5, 4'h7, 4'h0, 4'hC};
    int miscompares = 0;
    int samples_checked = 0;

    rwi_top dut (.core_clk(core_clk), .rst_n(rst_n), .resetIsPower(resetIsPower),
        .bit6Present(bit6Present), .oscMode(oscMode), .sleepReq(sleepReq),
        .watchdogWake(watchdogWake),
        .lowIrq(lowIrq), .highIrq(highIrq), .lowGlobalEnable(lowGlobalEnable),
        .highGlobalEnable(highGlobalEnable), .currentPc(currentPc), .flagClr(flagClr),
        .portAPin(portAPin), .dataWe(dataWe), .dataSel(dataSel), .dataWrData(dataWrData),
        .dataRdData(dataRdData), .progAddr(progAddr), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .asleep(asleep), .wakeFlags(wakeFlags),
        .portALatch(portALatch), .portADir(portADir), .portAPinRead(portAPinRead),
        .stackTopUpper(stackTopUpper), .stackTopHigh(stackTopHigh),
        .stackTopLow(stackTopLow), .stackPtr(stackPtr), .stackFull(stackFull));

    // ************************************************
    // Clock, compare and closing tasks
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk21(input string name, input logic [20:0] exp, input logic [20:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ************************************************
    // Access tasks
    // ************************************************
    task automatic do_reset(input logic p, input logic b6);
        @(posedge core_clk);
        rst_n <= 1'b0;
        resetIsPower <= p;
        bit6Present <= b6;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        expPtr = 5'h00;
    endtask

    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge core_clk);
        dataWe <= 1'b1;
        dataSel <= sel;
        dataWrData <= d;
        @(posedge core_clk);
        dataWe <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
        @(posedge core_clk);
        dataSel <= sel;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk8("dataRdData", exp, dataRdData);
    endtask

    task automatic do_wake(input logic [2:0] ev, input logic [1:0] en, input logic [20:0] pc,
                           input logic [20:0] target, input logic push, input logic [7:0] flag);
        int n;
        @(posedge core_clk);
        currentPc <= pc;
        {lowGlobalEnable, highGlobalEnable} <= en;
        sleepReq <= 1'b1;
        @(posedge core_clk);
        sleepReq <= 1'b0;
        n = 0;
        @(negedge core_clk);
        while (asleep !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        chk8("asleep", 8'h01, {7'h0, asleep});
        @(posedge core_clk);
        {watchdogWake, lowIrq, highIrq} <= ev;
        @(posedge core_clk);
        {watchdogWake, lowIrq, highIrq} <= 3'h0;
        @(negedge core_clk);
        if (push && expPtr != 5'h1F) expPtr = expPtr + 5'h01;
        chk8("pcLoad", 8'h01, {7'h0, pcLoad});
        chk21("pcLoadValue", target, pcLoadValue);
        chk8("stackPtr", {3'h0, expPtr}, {3'h0, stackPtr});
        if (push) begin
            chk8("stackTopUpper", {3'h0, pc[20:16]}, stackTopUpper);
            chk8("stackTopHigh", pc[15:8], stackTopHigh);
            chk8("stackTopLow", pc[7:0], stackTopLow);
        end
        chk8("wakeFlags", flag, wakeFlags);
        @(negedge core_clk);
        chk8("pcLoad", 8'h00, {7'h0, pcLoad});
        chk8("asleep", 8'h00, {7'h0, asleep});
        @(posedge core_clk);
        flagClr <= 8'hFF;
        @(posedge core_clk);
        flagClr <= 8'h00;
        @(negedge core_clk);
        chk8("wakeFlags", 8'h00, wakeFlags);
    endtask

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        #(50 * 4000);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        {rst_n, sleepReq, watchdogWake, lowIrq, highIrq, dataWe} = 6'h00;
        {lowGlobalEnable, highGlobalEnable, resetIsPower, bit6Present} = 4'hB;
        {oscMode, currentPc, flagClr, portAPin} = {rwi_pkg::OSC_EXT_IO, 21'h0, 8'h00, 8'hFF};
        {dataSel, dataWrData, expPtr} = 15'h0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk8("portADir", rwi_pkg::PA_DIR_RESET, portADir);
        chk8("portALatch", 8'h00, portALatch);
        chk8("wakeFlags", rwi_pkg::FLAGS_RESET, wakeFlags);
        chk8("stackPtr", 8'h00, {3'h0, stackPtr});
        chk8("stackFull", 8'h00, {7'h0, stackFull});
        $display("test reset_values done");
        @(posedge core_clk);
        currentPc <= 21'h1F00A1;
        wr(rwi_pkg::SEL_LATCH, 8'hFF);
        @(negedge core_clk);
        chk21("progAddr", 21'h1F00A1, progAddr);
        rd(rwi_pkg::SEL_LATCH, 8'h7F);
        wr(rwi_pkg::SEL_DIR, 8'h00);
        rd(rwi_pkg::SEL_DIR, 8'h00);
        wr(rwi_pkg::SEL_DIR, 8'hFF);
        rd(rwi_pkg::SEL_DIR, 8'h7F);
        rd(rwi_pkg::SEL_PIN, 8'h7F);
        wr(rwi_pkg::SEL_FLAGS, 8'hFF);
        rd(rwi_pkg::SEL_FLAGS, 8'h00);
        $display("test data_port done");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            oscMode <= modes[i];
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            bit6Exp = (modes[i] == rwi_pkg::OSC_EXT_IO || modes[i] == rwi_pkg::OSC_RC_IO)
                ? 8'h40 : 8'h00;
            chk8("portALatch", 8'h3F | bit6Exp, portALatch);
            chk8("portADir", 8'h3F | bit6Exp, portADir);
            chk8("portAPinRead", 8'h3F | bit6Exp, portAPinRead);
        end
        $display("test osc_modes done");
        @(posedge core_clk);
        oscMode <= rwi_pkg::OSC_EXT_IO;
        do_wake(3'h1, 2'h1, 21'h012345, rwi_pkg::VEC_HIGH, 1'b1, 8'h04);
        do_wake(3'h2, 2'h2, 21'h1ABCDE, rwi_pkg::VEC_LOW, 1'b1, 8'h02);
        do_wake(3'h1, 2'h2, 21'h0F0F0F, rwi_pkg::VEC_LOW, 1'b1, 8'h04);
        for (int k = 0; k < 29; k++) begin
            do_wake(3'h1, 2'h1, 21'h012345, rwi_pkg::VEC_HIGH, 1'b1, 8'h04);
        end
        chk8("stackFull", 8'h01, {7'h0, stackFull});
        do_wake(3'h4, 2'h3, 21'h054321, 21'h054321, 1'b0, 8'h01);
        do_wake(3'h2, 2'h0, 21'h1000C3, 21'h1000C3, 1'b0, 8'h02);
        $display("test wakes done");
        do_reset(1'b0, 1'b1);
        chk8("portALatch", 8'h7F, portALatch);
        chk8("portADir", rwi_pkg::PA_DIR_RESET, portADir);
        chk8("stackPtr", 8'h00, {3'h0, stackPtr});
        $display("test warm_reset done");
        do_reset(1'b1, 1'b0);
        chk8("portALatch", 8'h00, portALatch);
        chk8("portADir", 8'h3F, portADir);
        chk8("portAPinRead", 8'h3F, portAPinRead);
        wr(rwi_pkg::SEL_LATCH, 8'hFF);
        rd(rwi_pkg::SEL_LATCH, 8'h3F);
        $display("test bit6_absent done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
